// >>> sssb_top.sv
// Serial buffer transfer with status and control over APB
// Function
// R1: Gap code 00/01/10/11 gives 0/8/24/56 cycles
// R2: Buffer access while busy sets wait flag
// R3: Flags clear by read one, write zero
// R4: External clock pulse after completion sets overrun
// R5: Start flag starts, stops, shows busy; CS aborts
// R6: Serial out level drives pin, reads pin
//
// Local design decisions: register access over APB and the address map.
module sssb_top
  import sssb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic sck_in,
  input wire logic cs_n_in,
  output logic sck_out,
  output logic sck_oe,
  output logic serial_data_out_pin
);
  // ****************************************
  // Declarations
  // ****************************************
  sssb_state_t state_r;          // Transfer state
  logic [4:0] start_r;           // First buffer index
  logic [4:0] end_r;             // Last buffer index
  logic [4:0] cur_r;             // Index being shifted
  logic [2:0] bit_r;             // Bit within byte
  logic [5:0] gap_r;             // Gap cycles left
  logic [1:0] gap_sel_r;         // Byte gap select
  logic ext_r;                   // External shift clock
  logic [3:0] div_r;             // Internal clock divider
  logic ph_r;                    // Internal clock phase
  logic done_r;                  // Last transfer completed
  logic sol_r;                   // Idle level of data pin
  logic abt_r, wt_r, overrun_error_flag_r;     // Error flags
  logic [2:0] seen_r;            // Flags read as one
  logic [NEV-1:0] ists_r;        // Sticky events
  logic [NEV-1:0] ien_r;         // Event enables
  logic sck_s, sck_d;            // Synced clock and delay
  logic cs_s, cs_d;              // Synced chip select and delay
  logic [7:0] buf_rdata;         // Buffer read data
  logic [4:0] buf_raddr;         // Buffer read index
  logic busy;                    // Transfer running or waiting
  logic access;                  // APB access phase
  logic acc_done;                // Completion edge of a transfer
  logic is_buf;                  // Address hits the buffer
  logic wr_ctrl, rd_ctrl;        // Control register accesses
  logic fall, rise;              // Shift clock edges
  logic ext_fall, ext_rise;      // External clock edges
  logic tick;                    // Internal half period elapsed
  logic last_byte;               // Current byte is the end one
  logic [5:0] gap_len;           // Selected gap length
  logic [NEV-1:0] ev;            // Events this cycle
  logic [31:0] rd_val;           // Read data mux
  logic hit;                     // Address is mapped
  // ****************************************
  // Pin synchronisers and buffer
  // ****************************************
  sssb_sync u_sck (
    .clk(pclk),
    .rst_n(presetn),
    .en(pclk_en),
    .d(sck_in),
    .q(sck_s)
  );
  sssb_sync u_cs (
    .clk(pclk),
    .rst_n(presetn),
    .en(pclk_en),
    .d(cs_n_in),
    .q(cs_s)
  );
  sssb_mem u_mem (
    .clk(pclk),
    .rst_n(presetn),
    .en(pclk_en),
    .we(acc_done && pwrite && is_buf && !busy),
    .waddr(paddr[6:2]),
    .wdata(pwdata[7:0]),
    .raddr(buf_raddr),
    .rdata(buf_rdata)
  );
  // ****************************************
  // Decode and clock edges
  // ****************************************
  assign busy = (state_r != ST_IDLE);
  assign access = psel && penable;
  assign acc_done = access && pready;
  assign is_buf = paddr[A_BUF_BIT];
  assign wr_ctrl = acc_done && pwrite && (paddr == A_CTRL);
  assign rd_ctrl = acc_done && !pwrite && (paddr == A_CTRL);
  // Shifter owns the buffer while busy
  assign buf_raddr = busy ? cur_r : paddr[6:2];
  assign ext_fall = sck_d && !sck_s;
  assign ext_rise = !sck_d && sck_s;
  assign tick = (div_r == SCK_HALF_CYC - 4'h1);
  assign fall = ext_r ? ext_fall : (tick && ph_r);
  assign rise = ext_r ? ext_rise : (tick && !ph_r);
  assign last_byte = (cur_r == end_r);
  // Gap length from the select code
  always_comb begin
    case (gap_sel_r) // R1
      2'b01: gap_len = GAP_LEN_1;
      2'b10: gap_len = GAP_LEN_2;
      2'b11: gap_len = GAP_LEN_3;
      default: gap_len = 6'h00;
    endcase
  end
  // Events that set the sticky flags
  always_comb begin
    ev = '0;
    ev[E_DONE] = (state_r == ST_SHIFT) && rise && (bit_r == 3'h7) &&
      last_byte;
    ev[E_ABT] = (state_r == ST_SHIFT || state_r == ST_GAP) &&
      cs_s && !cs_d; // R5
    ev[E_WT] = acc_done && is_buf && busy; // R2
    ev[E_OVERRUN_ERROR_FLAG] = ext_r && !busy && done_r && ext_fall; // R4
  end
  // ****************************************
  // Edge detect delays
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_d <= 1'b1;
      cs_d <= 1'b1;
    end else if (pclk_en) begin
      sck_d <= sck_s;
      cs_d <= cs_s;
    end
  end
  // ****************************************
  // Transfer state machine and shifter
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      cur_r <= 5'h00;
      bit_r <= 3'h0;
      gap_r <= 6'h00;
      done_r <= 1'b0;
      serial_data_out_pin <= 1'b0;
    end else if (pclk_en) begin
      if ((wr_ctrl && !pwdata[B_STF]) || ev[E_ABT]) begin
        // Write of zero or chip select rising stops at once
        state_r <= ST_IDLE; // R5
      end else begin
        case (state_r)
          ST_IDLE: begin
            serial_data_out_pin <= sol_r; // R6
            if (wr_ctrl && pwdata[B_STF]) begin
              state_r <= ST_WAIT_CS; // R5
              cur_r <= start_r;
              bit_r <= 3'h0;
              done_r <= 1'b0;
            end
          end
          ST_WAIT_CS: begin
            // Chip select low starts shifting
            if (!cs_s) begin
              state_r <= ST_SHIFT;
            end
          end
          ST_SHIFT: begin
            if (fall) begin
              serial_data_out_pin <= buf_rdata[3'h7 - bit_r];
            end
            if (rise) begin
              bit_r <= bit_r + 3'h1;
              if (bit_r == 3'h7) begin
                if (last_byte) begin
                  state_r <= ST_IDLE;
                  done_r <= 1'b1;
                end else begin
                  cur_r <= cur_r + 5'h01;
                  gap_r <= gap_len; // R1
                  if (gap_len != 6'h00) begin
                    state_r <= ST_GAP; // R1
                  end
                end
              end
            end
          end
          ST_GAP: begin
            // Idle serial cycles between bytes
            if (rise) begin
              gap_r <= gap_r - 6'h01; // R1
              if (gap_r == 6'h01) begin
                state_r <= ST_SHIFT; // R1
              end
            end
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end
  // ****************************************
  // Internal shift clock
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 4'h0;
      ph_r <= 1'b1;
      sck_out <= 1'b1;
      sck_oe <= 1'b0;
    end else if (pclk_en) begin
      sck_oe <= !ext_r;
      if (!ext_r && (state_r == ST_SHIFT || state_r == ST_GAP)) begin
        div_r <= tick ? 4'h0 : div_r + 4'h1;
        if (tick) begin
          ph_r <= !ph_r;
          // Clock held high through the gap
          sck_out <= (state_r == ST_SHIFT) ? !ph_r : 1'b1; // R1
        end
      end else begin
        div_r <= 4'h0;
        ph_r <= 1'b1;
        sck_out <= 1'b1;
      end
    end
  end
  // ****************************************
  // Error flags
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abt_r <= 1'b0;
      wt_r <= 1'b0;
      overrun_error_flag_r <= 1'b0;
      seen_r <= 3'h0;
    end else if (pclk_en) begin
      // Zero clears only after one was read; set wins
      abt_r <= ev[E_ABT] || (abt_r && !(wr_ctrl && !pwdata[B_ABT] &&
        seen_r[0])); // R3
      wt_r <= ev[E_WT] || (wt_r && !(wr_ctrl && !pwdata[B_WT] &&
        seen_r[1])); // R3
      overrun_error_flag_r <= ev[E_OVERRUN_ERROR_FLAG] || (overrun_error_flag_r && !(wr_ctrl && !pwdata[B_OVERRUN_ERROR_FLAG] &&
        seen_r[2])); // R3
      if (rd_ctrl) begin
        seen_r <= {overrun_error_flag_r, wt_r, abt_r}; // R3
      end else if (wr_ctrl) begin
        seen_r <= 3'h0;
      end
    end
  end
  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sol_r <= 1'b0;
      gap_sel_r <= 2'h0;
      ext_r <= 1'b0;
      start_r <= 5'h00;
      end_r <= 5'h00;
      ien_r <= '0;
    end else if (pclk_en && acc_done && pwrite) begin
      case (paddr)
        A_CTRL: sol_r <= pwdata[B_SOL]; // R6
        A_CFG: begin
          gap_sel_r <= pwdata[B_GAP_HI:B_GAP_LO];
          ext_r <= pwdata[B_EXT];
        end
        A_START: start_r <= pwdata[4:0];
        A_END: end_r <= pwdata[4:0];
        A_IEN: ien_r <= pwdata[NEV-1:0];
        default: ;
      endcase
    end
  end
  // ****************************************
  // Interrupt status and output
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ists_r <= '0;
      irq <= 1'b0;
    end else if (pclk_en) begin
      // Write one clears; a new event wins
      ists_r <= ev | (ists_r & ~({NEV{acc_done && pwrite &&
        paddr == A_ICLR}} & pwdata[NEV-1:0]));
      irq <= |(ists_r & ien_r);
    end
  end
  // ****************************************
  // APB read mux
  // ****************************************
  always_comb begin
    rd_val = 32'h0000_0000;
    hit = 1'b1;
    if (is_buf) begin
      // Busy buffer reads as zero
      rd_val[7:0] = busy ? 8'h00 : buf_rdata; // R2
    end else begin
      case (paddr)
        A_CTRL: rd_val[7:0] = {CTRL_UNUSED, serial_data_out_pin, overrun_error_flag_r,
          wt_r, abt_r, busy}; // R5 R6
        A_CFG: rd_val[7:0] = {3'h0, gap_sel_r, ext_r, 2'h0};
        A_START: rd_val[4:0] = start_r;
        A_END: rd_val[4:0] = end_r;
        A_ISTS: rd_val[NEV-1:0] = ists_r;
        A_IEN: rd_val[NEV-1:0] = ien_r;
        A_ICLR: rd_val = 32'h0000_0000;
        default: hit = 1'b0;
      endcase
    end
  end
  // ****************************************
  // APB answer: ready in second access cycle
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (pclk_en) begin
      pready <= access && !pready;
      pslverr <= access && !pready && !hit;
      if (access && !pready) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_val;
      end
    end
  end
endmodule

// >>> sssb_pkg.sv
// Constants, register map and state type of the serial buffer status block
package sssb_pkg;
  // ****************************************
  // Register byte offsets on the APB
  // ****************************************
  localparam logic [7:0] A_CTRL = 8'h00;  // Status and control
  localparam logic [7:0] A_CFG = 8'h04;   // Gap and clock source
  localparam logic [7:0] A_START = 8'h08; // Buffer start index
  localparam logic [7:0] A_END = 8'h0c;   // Buffer end index
  localparam logic [7:0] A_ISTS = 8'h10;  // Interrupt status, read only
  localparam logic [7:0] A_IEN = 8'h14;   // Interrupt enable
  localparam logic [7:0] A_ICLR = 8'h18;  // Interrupt clear, write only
  localparam int A_BUF_BIT = 7;           // Address bit that selects buffer

  // ****************************************
  // Field positions
  // ****************************************
  localparam int B_STF = 0;     // Start flag
  localparam int B_ABT = 1;     // Abort flag
  localparam int B_WT = 2;      // Buffer wait flag
  localparam int B_OVERRUN_ERROR_FLAG = 3;    // Overrun error flag
  localparam int B_SOL = 4;     // Serial out level
  localparam int B_EXT = 2;     // External shift clock select
  localparam int B_GAP_LO = 3;  // Byte gap select low
  localparam int B_GAP_HI = 4;  // Byte gap select high
  localparam logic [2:0] CTRL_UNUSED = 3'h7; // Unused bits read one

  // ****************************************
  // Event bits of the interrupt registers
  // ****************************************
  localparam int E_DONE = 0;
  localparam int E_ABT = 1;
  localparam int E_WT = 2;
  localparam int E_OVERRUN_ERROR_FLAG = 3;
  localparam int NEV = 4;

  // ****************************************
  // Gap lengths in serial clock cycles
  // ****************************************
  localparam logic [5:0] GAP_LEN_1 = 6'h08;
  localparam logic [5:0] GAP_LEN_2 = 6'h18;
  localparam logic [5:0] GAP_LEN_3 = 6'h38;

  // ****************************************
  // Timing of the internal shift clock
  // ****************************************
  localparam int CLK_NS = 10;        // pclk period
  localparam int SCK_HALF_NS = 40;   // Internal half period, least time
  localparam logic [3:0] SCK_HALF_CYC =
    4'((SCK_HALF_NS + CLK_NS - 1) / CLK_NS);

  // ****************************************
  // Transfer states
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT_CS = 2'b01,
    ST_SHIFT = 2'b10,
    ST_GAP = 2'b11
  } sssb_state_t;
endpackage

// >>> sssb_sync.sv
// Two flip-flop synchroniser for one pin input
module sssb_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic d,
  output logic q
);
  logic meta_r; // First stage, read only by the second

  // Two stages, frozen with the clock enable; reset to idle high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b1;
      q <= 1'b1;
    end else if (en) begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// >>> sssb_mem.sv
// The 32-byte serial data buffer with registered read data
module sssb_mem (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic we,
  input wire logic [4:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [4:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [32]; // Buffer bytes, no reset

  // Write port
  always_ff @(posedge clk) begin
    if (en && we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (en) begin
      rdata <= mem[raddr];
    end
  end
endmodule

// >>> sssb_chk.sv
// Port checks of the serial buffer status block
module sssb_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cs_n_in,
  input wire logic sck_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // *********************
  // Shift clock phases
  // *********************
  // Low phase lasts exactly four cycles
  sequence s_low4;
    (!sck_out) [*4] ##1 sck_out;
  endsequence
  // High phase lasts at least four cycles
  sequence s_high4;
    sck_out [*4];
  endsequence
  a_ready_late: assert property (psel && penable && !pready |=> pready)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_sck_low: assert property ($fell(sck_out) |-> s_low4)
    else $error("shift clock low phase wrong");
  a_sck_high: assert property ($rose(sck_out) |-> s_high4)
    else $error("shift clock high phase short");
  a_clk_cs: assert property ($fell(sck_out) |-> !$past(cs_n_in, 2) ||
    !$past(cs_n_in, 3) || !$past(cs_n_in, 4))
    else $error("shift clock without chip select");
endmodule

// >>> sssb_peer.sv
// Far serial device: chip select, own clock, byte capture
module sssb_peer (
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic serial_data_out_pin,
  output logic sck_in,
  output logic cs_n_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic ext_clk = 1'b1; // Own clock, stands high between frames
  logic cs_req = 1'b0; // Select request from the bench
  logic [7:0] sh = 8'h00; // Incoming bits
  int nbit = 0; // Bits of the current byte
  logic [7:0] rxq[$]; // Bytes received
  realtime rise_t[$]; // Time of each rising edge while selected
  assign cs_n_in = !cs_req;
  // Wire level: whoever enables drives it
  assign sck_in = sck_oe ? sck_out : ext_clk;
  // Take one bit per rising edge while selected, MSB first
  always @(posedge sck_in) begin
    if (!cs_n_in) begin
      rise_t.push_back($realtime);
      sh = {sh[6:0], serial_data_out_pin};
      nbit++;
      if (nbit == 8) begin
        rxq.push_back(sh);
        nbit = 0;
      end
    end
  end
  // Deselect drops a partial byte
  always @(posedge cs_n_in) begin
    nbit = 0;
  end
  // Burst of own clock pulses, 125 ns period
  task automatic pulses(input int n);
    repeat (n) begin
      #62.5 ext_clk = 1'b0;
      #62.5 ext_clk = 1'b1;
    end
  endtask
endmodule

// >>> sssb_top_tb.sv
// Self-checking bench of the serial buffer status block
module sssb_top_tb import sssb_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, irq, sck_in, cs_n_in;
  logic sck_out, sck_oe, sdo;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  int fails = 0, n_checks = 0, cyc = 0, t;
  logic [7:0] bv[2]; // Buffer contents
  logic [7:0] regs[6] = '{A_CFG, A_START, A_END, A_ISTS, A_IEN, A_ICLR};
  int gl[4] = '{0, 8, 24, 56}; // Gap lengths per code
  realtime dt;
  logic [31:0] exp_d[$], exp_m[$]; // Notes: data and mask
  logic exp_e[$]; // Notes: error response
  always #5 pclk = ~pclk;
  sssb_top u_sssb_top (.pclk(pclk), .presetn(presetn), .pclk_en(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .sck_in(sck_in), .cs_n_in(cs_n_in), .sck_out(sck_out),
    .sck_oe(sck_oe), .serial_data_out_pin(sdo));
  sssb_peer u_sssb_peer (.sck_out(sck_out), .sck_oe(sck_oe),
    .serial_data_out_pin(sdo), .sck_in(sck_in), .cs_n_in(cs_n_in));
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // APB transfer; notes the expected answer first
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [31:0] m, input logic e);
    exp_d.push_back(d & m);
    exp_m.push_back(m);
    exp_e.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    apb(1'b0, a, d, 32'hffffffff, 1'b0);
  endtask
  // Poll until the start flag reads zero
  task automatic wait_idle();
    t = 0;
    do apb(1'b0, A_CTRL, 32'h0, 32'h0, 1'b0);
    while (rv[B_STF] !== 1'b0 && ++t < 400);
    chk(32'(rv[B_STF]), 32'h0);
  endtask
  // *********************
  // Answer monitor
  // *********************
  // Oldest note against each completed transfer
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      chk(32'(pslverr), 32'(exp_e.pop_front()));
      chk(prdata & exp_m.pop_front(), exp_d.pop_front());
    end
  end
  // Hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      results();
    end
  end
  // *********************
  // Tests
  // *********************
  initial begin
    void'($urandom(57400));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(A_CTRL, 32'he0);
    foreach (regs[i]) rd(regs[i], 32'h0);
    apb(1'b0, 8'h1c, 32'h0, 32'hffffffff, 1'b1);
    $display("test reset done");
    // Two random bytes, every gap code
    foreach (bv[i]) begin
      bv[i] = 8'($urandom);
      wr(8'h80 + 8'(4 * i), {24'h0, bv[i]});
    end
    wr(A_END, 32'h1);
    wr(A_IEN, 32'h1);
    u_sssb_peer.cs_req <= 1'b1;
    for (int g = 0; g < 4; g++) begin
      u_sssb_peer.rise_t.delete();
      wr(A_CFG, 32'(g) << 3);
      wr(A_CTRL, 32'h1);
      wait_idle();
      chk(32'(u_sssb_peer.rxq.pop_front()), {24'h0, bv[0]});
      chk(32'(u_sssb_peer.rxq.pop_front()), {24'h0, bv[1]});
      dt = u_sssb_peer.rise_t[8] - u_sssb_peer.rise_t[7];
      chk(32'(dt == (gl[g] + 1) * 2 * SCK_HALF_CYC * CLK_NS), 32'h1);
    end
    chk(32'(irq), 32'h1);
    wr(A_IEN, 32'h0);
    rd(A_ISTS, 32'h1);
    chk(32'(irq), 32'h0);
    wr(A_ICLR, 32'hf);
    rd(A_ISTS, 32'h0);
    $display("test gaps done");
    // Buffer access while waiting for select
    u_sssb_peer.cs_req <= 1'b0;
    wr(A_CFG, 32'h0);
    wr(A_CTRL, 32'h1);
    rd(8'h80, 32'h0);
    wr(8'h84, 32'h5a);
    rd(A_CTRL, 32'he5);
    wr(A_CTRL, 32'h5);
    rd(A_CTRL, 32'he5);
    wr(A_CTRL, 32'h1);
    rd(A_CTRL, 32'he1);
    wr(A_CTRL, 32'h0);
    rd(A_CTRL, 32'he0);
    rd(8'h84, {24'h0, bv[1]});
    rd(A_ISTS, 32'h4);
    $display("test wait done");
    // Deselect in the gap aborts
    wr(A_ICLR, 32'hf);
    wr(A_CFG, 32'h18);
    u_sssb_peer.cs_req <= 1'b1;
    wr(A_CTRL, 32'h1);
    t = 0;
    while (u_sssb_peer.rxq.size() == 0 && t++ < 500) @(posedge pclk);
    u_sssb_peer.cs_req <= 1'b0;
    repeat (10) @(posedge pclk);
    rd(A_CTRL, 32'he2);
    wr(A_CTRL, 32'h0);
    rd(A_CTRL, 32'he0);
    rd(A_ISTS, 32'h2);
    chk(32'(u_sssb_peer.rxq.size()), 32'h1);
    u_sssb_peer.rxq.delete();
    $display("test abort done");
    // Own clock: one byte, then one pulse too many
    wr(A_CFG, 32'h4);
    wr(A_START, 32'h1);
    u_sssb_peer.cs_req <= 1'b1;
    wr(A_CTRL, 32'h1);
    chk(32'(sck_oe), 32'h0);
    u_sssb_peer.pulses(8);
    repeat (8) @(posedge pclk);
    rd(A_CTRL, 32'he0);
    chk(32'(u_sssb_peer.rxq.pop_front()), {24'h0, bv[1]});
    u_sssb_peer.pulses(1);
    repeat (8) @(posedge pclk);
    rd(A_CTRL, 32'he8);
    wr(A_CTRL, 32'h0);
    rd(A_CTRL, 32'he0);
    $display("test overrun done");
    // Output level bit drives and reads the pin
    wr(A_CTRL, 32'h10);
    rd(A_CTRL, 32'hf0);
    chk(32'(sdo), 32'h1);
    wr(A_CTRL, 32'h0);
    rd(A_CTRL, 32'he0);
    chk(32'(sdo), 32'h0);
    $display("test level done");
    results();
  end
endmodule
bind sssb_top sssb_chk u_sssb_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .cs_n_in(cs_n_in),
  .sck_out(sck_out));
